// ==== rtl/pfs_map.svh ====
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// register map
`define PFS_ADDR_FAULT1 8'h03
`define PFS_NUM_FLAGS 3
`define PFS_BIT_OVERCURRENT 0
`define PFS_BIT_BACKBIAS 1
`define PFS_BIT_SUPPLY_OV 2
`define PFS_FLAGS_RESET 3'h0
`define PFS_UPPER_READ 5'h00
`define PFS_RDATA_RESET 8'h00
`define PFS_UNMAPPED_READ 8'h00

`endif

// ==== rtl/pfs_pkg.sv ====
package pfs_pkg;
  typedef logic [7:0] pfs_addr_t;
  typedef logic [7:0] pfs_data_t;
endpackage

// ==== rtl/pfs_flag_if.sv ====
`timescale 1ns/1ps
interface pfs_flag_if;
  logic cond;
  logic rd_clr;
  logic err_clr;
  logic flag;
  logic newly_set;
  modport latch (
    input cond,
    input rd_clr,
    input err_clr,
    output flag,
    output newly_set
  );
  modport ctrl (
    output cond,
    output rd_clr,
    output err_clr,
    input flag,
    input newly_set
  );
endinterface

// ==== rtl/pfs_fault_latch.sv ====
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_fault_latch (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // flag link
  pfs_flag_if.latch fl
);
  import pfs_pkg::*;

  logic flag;
  logic next_flag;

  // a present fault beats any clear in the same cycle, so no event is lost
  always_comb begin
    next_flag = flag;
    if (fl.err_clr) begin
      next_flag = 1'b0;
    end
    if (fl.rd_clr && !fl.cond) begin
      next_flag = 1'b0;
    end
    if (fl.cond) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign fl.flag = flag;
  assign fl.newly_set = fl.cond && !flag;
endmodule

// ==== rtl/pfs_top.sv ====
`timescale 1ns/1ps
`include "pfs_map.svh"
// Behaviour
// - supply overvoltage latches bit 2 and enters the Error state
// - supply overvoltage bit asserts both port-1 and port-2 alerts
// - bus exceeding supply or core by 150 mV latches bit 1
// - bit 0 latches only above both current limit and minimum trip
// - a read clears bits whose fault is gone; persisting faults stay set
// - clearing the port-1 error flag clears these bits too
// - back-bias or overcurrent asserts port-1 alert and enters Error state
// - port-1 alert follows latched bits, independent of the error flag
module pfs_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // analogue comparator results, synchronous
  input wire logic supply_overvoltage_threshold,
  input wire logic port1_bus_above_supply,
  input wire logic port1_bus_above_core,
  input wire logic port1_above_current_limit,
  input wire logic port1_above_minimum_trip,
  // from port-1 error flag logic
  input wire logic port1_error_flag_clear,
  // register read port
  input wire logic reg_rd,
  input wire pfs_pkg::pfs_addr_t reg_addr,
  output pfs_pkg::pfs_data_t reg_rdata,
  // alerts and error state entry
  output logic port1_alert,
  output logic port2_alert,
  output logic error_entry
);
  import pfs_pkg::*;

  logic [`PFS_NUM_FLAGS-1:0] cond;
  logic [`PFS_NUM_FLAGS-1:0] flags;
  logic [`PFS_NUM_FLAGS-1:0] newly;
  logic read_hit;
  pfs_data_t next_rdata;
  logic next_error_entry;

  // comparator qualification; margins are applied in the analogue front end
  always_comb begin
    cond = `PFS_FLAGS_RESET;
    cond[`PFS_BIT_SUPPLY_OV] = supply_overvoltage_threshold;
    cond[`PFS_BIT_BACKBIAS] = port1_bus_above_supply || port1_bus_above_core;
    cond[`PFS_BIT_OVERCURRENT] = port1_above_current_limit && port1_above_minimum_trip;
  end

  assign read_hit = reg_rd && (reg_addr == `PFS_ADDR_FAULT1);

  pfs_flag_if fl [`PFS_NUM_FLAGS] ();

  genvar i;
  generate
    for (i = 0; i < `PFS_NUM_FLAGS; i++) begin : g_flag
      assign fl[i].cond = cond[i];
      assign fl[i].rd_clr = read_hit;
      assign fl[i].err_clr = port1_error_flag_clear;
      assign flags[i] = fl[i].flag;
      assign newly[i] = fl[i].newly_set;
      pfs_fault_latch u_latch (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .fl(fl[i])
      );
      // per-bit latch checks; the pin-level checks sit after the read logic
      bit_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cond[i] |=> flags[i])
        else $error("present fault did not hold its bit");
      bit_read_clr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        read_hit && !cond[i] |=> !flags[i])
        else $error("read left a removed fault set");
      bit_err_clr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        port1_error_flag_clear && !cond[i] |=> !flags[i])
        else $error("error flag clear left a removed fault set");
      bit_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !read_hit && !port1_error_flag_clear |=> flags[i] || !$past(flags[i]))
        else $error("bit dropped without a clear");
      bit_no_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !flags[i] && !cond[i] |=> !flags[i])
        else $error("bit set without its fault");
    end
  endgenerate

  // read returns the value before the clear takes effect
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = `PFS_UNMAPPED_READ;
      if (read_hit) begin
        next_rdata = {`PFS_UPPER_READ, flags};
      end
    end
    next_error_entry = |newly;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `PFS_RDATA_RESET;
      error_entry <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      error_entry <= next_error_entry;
    end
  end

  // alerts follow the latched bits only, so they may release with the error flag still set
  assign port1_alert = |flags;
  assign port2_alert = flags[`PFS_BIT_SUPPLY_OV];

  sequence s_read_hit;
    reg_rd && (reg_addr == `PFS_ADDR_FAULT1);
  endsequence

  sequence s_ocur_rise;
    !flags[`PFS_BIT_OVERCURRENT] && port1_above_current_limit && port1_above_minimum_trip;
  endsequence

  sequence s_miss_read;
    reg_rd && (reg_addr != `PFS_ADDR_FAULT1);
  endsequence

  sequence s_clean_read;
    s_read_hit ##0 (cond == `PFS_FLAGS_RESET);
  endsequence

  ov_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    supply_overvoltage_threshold |=> flags[`PFS_BIT_SUPPLY_OV] && port2_alert)
    else $error("supply overvoltage not latched");

  dual_alert_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    flags[`PFS_BIT_SUPPLY_OV] |-> port1_alert && port2_alert)
    else $error("overvoltage must raise both alerts");

  backbias_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (port1_bus_above_supply || port1_bus_above_core) |=> flags[`PFS_BIT_BACKBIAS])
    else $error("back-bias not latched");

  ocur_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !flags[`PFS_BIT_OVERCURRENT]
      && !(port1_above_current_limit && port1_above_minimum_trip)
      |=> !flags[`PFS_BIT_OVERCURRENT])
    else $error("overcurrent set without both thresholds");

  read_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_read_hit ##0 (cond == `PFS_FLAGS_RESET) |=> flags == `PFS_FLAGS_RESET)
    else $error("read did not clear removed faults");

  read_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_read_hit |=> reg_rdata == {`PFS_UPPER_READ, $past(flags)})
    else $error("read data wrong");

  read_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_read_hit ##0 cond[`PFS_BIT_BACKBIAS] |=> flags[`PFS_BIT_BACKBIAS])
    else $error("persisting fault cleared by read");

  err_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    port1_error_flag_clear && (cond == `PFS_FLAGS_RESET) |=> flags == `PFS_FLAGS_RESET)
    else $error("error flag clear left bits set");

  entry_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_ocur_rise |=> (error_entry && port1_alert) ##1
      (!error_entry || (($past(cond) & ~$past(flags)) != `PFS_FLAGS_RESET)))
    else $error("overcurrent did not enter error state");

  alert_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    port1_alert ##0 s_read_hit ##0 (cond == `PFS_FLAGS_RESET) |=> !port1_alert)
    else $error("alert did not release on read");

  ov_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !flags[`PFS_BIT_SUPPLY_OV] && !supply_overvoltage_threshold
      |=> !flags[`PFS_BIT_SUPPLY_OV])
    else $error("overvoltage set without its fault");

  backbias_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !flags[`PFS_BIT_BACKBIAS] && !port1_bus_above_supply && !port1_bus_above_core
      |=> !flags[`PFS_BIT_BACKBIAS])
    else $error("back-bias set without a bus excess");

  ocur_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    port1_above_current_limit && port1_above_minimum_trip
      |=> flags[`PFS_BIT_OVERCURRENT] && port1_alert)
    else $error("overcurrent not latched");

  p2_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_read_hit ##0 !supply_overvoltage_threshold |=> !port2_alert)
    else $error("port-2 alert held after a clean read");

  entry_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    error_entry |-> (flags & ~$past(flags)) != `PFS_FLAGS_RESET)
    else $error("error entry without a new bit");

  entry_alert_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    error_entry |-> port1_alert)
    else $error("error entry without port-1 alert");

  entry_once_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    error_entry && ((cond & ~flags) == `PFS_FLAGS_RESET)
      |=> !error_entry)
    else $error("error entry longer than one cycle");

  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  miss_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_miss_read |=> reg_rdata == `PFS_UNMAPPED_READ)
    else $error("other address returned data");

  miss_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_miss_read ##0 !port1_error_flag_clear
      |=> flags == ($past(flags) | $past(cond)))
    else $error("read of another address changed the bits");

  reread_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_clean_read ##1 (cond == `PFS_FLAGS_RESET) ##1 s_clean_read
      |=> reg_rdata == {`PFS_UPPER_READ, `PFS_FLAGS_RESET})
    else $error("second read after a clean read not zero");

  err_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    port1_error_flag_clear && supply_overvoltage_threshold |=> port2_alert)
    else $error("error flag clear beat a present fault");

  clr_alert_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    port1_error_flag_clear && (cond == `PFS_FLAGS_RESET)
      |=> !port1_alert && !port2_alert)
    else $error("alerts held after error flag clear");
endmodule

// ==== dv/pfs_host.sv ====
`timescale 1ns/1ps
module pfs_host (
  // clock
  input wire logic sys_clk,
  // read port
  output logic reg_rd,
  output pfs_pkg::pfs_addr_t reg_addr,
  input wire pfs_pkg::pfs_data_t reg_rdata
);
  import pfs_pkg::*;
  initial begin
    reg_rd = 1'b0;
    reg_addr = 8'h00;
  end
  // one strobe per read; data is taken after the next edge
  task automatic rd(input pfs_addr_t a, output pfs_data_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import pfs_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  // ov, above supply, above core, above limit, above trip
  logic [4:0] cond = 5'h00;
  logic clr = 1'b0;
  logic reg_rd, p1a, p2a, ent;
  pfs_addr_t reg_addr;
  pfs_data_t reg_rdata, d;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [4:0] row_in [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03};
  logic [7:0] row_exp [6] = '{8'h04, 8'h02, 8'h02, 8'h00, 8'h00, 8'h01};
  always #5 sys_clk = ~sys_clk;
  pfs_top i_pfs_top (.sys_clk(sys_clk), .arst_n(arst_n),
    .supply_overvoltage_threshold(cond[4]), .port1_bus_above_supply(cond[3]),
    .port1_bus_above_core(cond[2]), .port1_above_current_limit(cond[1]),
    .port1_above_minimum_trip(cond[0]), .port1_error_flag_clear(clr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .port1_alert(p1a), .port2_alert(p2a), .error_entry(ent));
  pfs_host i_pfs_host (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // fault held for one edge only
  task automatic pulse(input logic [4:0] c);
    @(posedge sys_clk);
    cond <= c;
    @(posedge sys_clk);
    cond <= 5'h00;
    #1;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    i_pfs_host.rd(8'h03, d);
    chk("rst_rdata", 8'h00, d);
    chk("rst_alerts", 8'h00, {5'h00, p1a, p2a, ent});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      pulse(row_in[i]);
      chk("alerts", {5'h00, |row_exp[i], row_exp[i][2], |row_exp[i]}, {5'h00, p1a, p2a, ent});
      i_pfs_host.rd(8'h03, d);
      chk("rdata", row_exp[i], d);
      i_pfs_host.rd(8'h03, d);
      chk("reread", 8'h00, d);
      chk("alerts_off", 8'h00, {5'h00, p1a, p2a, ent});
    end
    $display("test rows done");
    @(posedge sys_clk);
    cond <= 5'h0C;
    i_pfs_host.rd(8'h03, d);
    i_pfs_host.rd(8'h03, d);
    chk("persist", 8'h02, d);
    @(posedge sys_clk);
    cond <= 5'h00;
    i_pfs_host.rd(8'h03, d);
    chk("last_read", 8'h02, d);
    i_pfs_host.rd(8'h03, d);
    chk("gone", 8'h00, d);
    $display("test persist done");
    @(posedge sys_clk);
    cond <= 5'h10;
    clr <= 1'b1;
    @(posedge sys_clk);
    cond <= 5'h00;
    #1 chk("clr_held", 8'h03, {6'h00, p2a, ent});
    @(posedge sys_clk);
    clr <= 1'b0;
    #1 chk("clr_alerts", 8'h00, {5'h00, p1a, p2a, ent});
    i_pfs_host.rd(8'h03, d);
    chk("clr_rdata", 8'h00, d);
    pulse(5'h03);
    i_pfs_host.rd(8'h04, d);
    chk("unmapped", 8'h00, d);
    i_pfs_host.rd(8'h03, d);
    chk("after_unmapped", 8'h01, d);
    $display("test clear and unmapped done");
    pulse(5'h10);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    #1 chk("rst_mid_alerts", 8'h00, {5'h00, p1a, p2a, ent});
    chk("rst_mid_rdata", 8'h00, reg_rdata);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    #1 chk("rst_mid_release", 8'h00, {5'h00, p1a, p2a, ent});
    i_pfs_host.rd(8'h03, d);
    chk("rst_mid_read", 8'h00, d);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
